//--- capture_compare_map.vh
// Constants for the four-channel capture/compare and encoder block.
// Assumes inclusion by bare name from the block's design files.
`ifndef CAPTURE_COMPARE_MAP_VH
`define CAPTURE_COMPARE_MAP_VH

// ************************************************************
// Channel mode field codes, four bits per channel
// ************************************************************
`define MODE_OFF 4'h0
`define MODE_CAP_RISE 4'h1
`define MODE_CAP_FALL 4'h2
`define MODE_CAP_BOTH 4'h3
`define MODE_FORCE_LOW 4'h8
`define MODE_FORCE_HIGH 4'h9
`define MODE_MATCH_LOW 4'ha
`define MODE_MATCH_HIGH 4'hb
`define MODE_PWM_POS 4'he
`define MODE_PWM_REV 4'hf
`define MODE_OUTPUT_BIT 3

// ************************************************************
// Capture source selector codes, three bits per channel
// ************************************************************
`define SRC_PIN 3'h0
`define SRC_UART_ONE 3'h1
`define SRC_UART_TWO 3'h2
`define SRC_COMP_ONE 3'h4
`define SRC_COMP_TWO 3'h5
`define SRC_LVD 3'h6

// ************************************************************
// Status flag positions and reset values
// ************************************************************
`define FLAG_CH_FIRST 0
`define FLAG_OVERFLOW 4
`define FLAG_DIR_CHANGE 5
`define FLAG_WIDTH 6
`define STATUS_RESET 6'h00
`define COUNTER_RESET 16'h0000
`define COMPARE_RESET 16'h0000
`define INDEX_CLEAR_VALUE 16'h0000

// ************************************************************
// Encoder select and index edge codes
// ************************************************************
`define ENC_OFF 2'h0
`define ENC_A_ONLY 2'h1
`define ENC_B_ONLY 2'h2
`define ENC_BOTH 2'h3
`define IDX_OFF 2'h0
`define IDX_RISE 2'h1
`define IDX_FALL 2'h2

`endif

//--- input_conditioner.v
// Input conditioner: polarity choice and a stability filter.
// Assumes the raw input is already synchronous to i_clk_sys.
`timescale 1ns/1ps
`default_nettype none

module input_conditioner #(
  parameter CNT_W = 8
) (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_raw,
  input wire i_invert,
  input wire [2:0] i_filter_code,
  output reg o_level
);

  // ************************************************************
  // Stability filter
  // ************************************************************
  wire adjusted;
  wire [CNT_W-1:0] needed;
  reg [CNT_W-1:0] stable_count;

  assign adjusted = i_raw ^ i_invert;
  assign needed = {{(CNT_W-1){1'b0}}, 1'b1} << i_filter_code;

  // A change passes only after it held for 2^code samples, so a
  // short glitch never reaches the edge logic; code 0 passes at once.
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stable_count <= {CNT_W{1'b0}};
      o_level <= 1'b0;
    end else if (adjusted == o_level) begin
      stable_count <= {CNT_W{1'b0}};
    end else if (i_filter_code == 3'h0 ||
                 stable_count + 1'b1 >= needed) begin
      stable_count <= {CNT_W{1'b0}};
      o_level <= adjusted;
    end else begin
      stable_count <= stable_count + 1'b1;
    end
  end

endmodule // input_conditioner

`default_nettype wire

//--- timer_capture_compare_encoder.v
// Four-channel capture/compare unit with quadrature encoder counting.
// Assumes all inputs are synchronous to i_clk_sys and that software
// drives the configuration ports as steady levels.
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_map.vh"

module timer_capture_compare_encoder #(
  parameter FILTER_CNT_W = 8
) (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_enable,
  input wire [3:0] i_prescale,
  input wire [15:0] i_reload_value,
  input wire i_counter_write,
  input wire [15:0] i_counter_wdata,
  input wire [15:0] i_channel_mode_control,
  input wire [11:0] i_capture_source_select,
  input wire [3:0] i_compare_write,
  input wire [15:0] i_compare_wdata,
  input wire [3:0] i_channel_pin,
  input wire i_uart_rx_one,
  input wire i_uart_rx_two,
  input wire i_voltage_comparator_one,
  input wire i_voltage_comparator_two,
  input wire i_low_voltage_detector_out,
  input wire [1:0] i_encoder_count_select,
  input wire i_input_a_polarity,
  input wire i_input_b_polarity,
  input wire [2:0] i_input_a_filter,
  input wire [2:0] i_input_b_filter,
  input wire [1:0] i_index_reload_edge,
  input wire [1:0] i_index_clear_edge,
  input wire [5:0] i_interrupt_enable_reg,
  input wire i_interrupt_clear_write,
  input wire [5:0] i_interrupt_clear_reg,
  output wire [15:0] o_counter_value,
  output wire [15:0] o_channel_compare_capture_1,
  output wire [15:0] o_channel_compare_capture_2,
  output wire [15:0] o_channel_compare_capture_3,
  output wire [15:0] o_channel_compare_capture_4,
  output reg [3:0] o_channel_out,
  output reg [5:0] o_interrupt_status,
  output reg o_direction,
  output reg o_overflow,
  output reg o_interrupt_request
);

  // ************************************************************
  // Functions
  // ************************************************************

  // Picks one capture source from its three-bit code.
  function source_pick;
    input [2:0] sel;
    input pin;
    begin
      if (sel == `SRC_PIN) begin
        source_pick = pin;
      end else if (sel == `SRC_UART_ONE) begin
        source_pick = i_uart_rx_one;
      end else if (sel == `SRC_UART_TWO) begin
        source_pick = i_uart_rx_two;
      end else if (sel == `SRC_COMP_ONE) begin
        source_pick = i_voltage_comparator_one;
      end else if (sel == `SRC_COMP_TWO) begin
        source_pick = i_voltage_comparator_two;
      end else if (sel == `SRC_LVD) begin
        source_pick = i_low_voltage_detector_out;
      end else begin
        source_pick = 1'b0;
      end
    end
  endfunction

  // Up step with wrap at the reload value; top bit marks overflow.
  function [16:0] step_up;
    input [15:0] value;
    input [15:0] limit;
    begin
      if (value >= limit) begin
        step_up = {1'b1, 16'h0000};
      end else begin
        step_up = {1'b0, value + 16'h0001};
      end
    end
  endfunction

  // Down step with wrap from zero to the reload value.
  function [16:0] step_down;
    input [15:0] value;
    input [15:0] limit;
    begin
      if (value == 16'h0000) begin
        step_down = {1'b1, limit};
      end else begin
        step_down = {1'b0, value - 16'h0001};
      end
    end
  endfunction

  // Edge qualification for the three capture modes.
  function edge_hit;
    input [3:0] mode;
    input rise;
    input fall;
    begin
      edge_hit = (mode == `MODE_CAP_RISE && rise) ||
                 (mode == `MODE_CAP_FALL && fall) ||
                 (mode == `MODE_CAP_BOTH && (rise || fall));
    end
  endfunction

  // ************************************************************
  // Input selection and conditioning
  // ************************************************************
  reg [15:0] counter_value;
  reg [15:0] ccr [0:3];
  reg [3:0] level_q;
  reg [3:0] match_q;
  reg [15:0] prescale_count;
  wire [3:0] raw_src;
  wire [3:0] level;
  wire [15:0] prescale_limit;
  wire tick;
  integer ch;

  // Each channel chooses its source before any edge logic.
  assign raw_src[0] = source_pick(i_capture_source_select[2:0],
                                  i_channel_pin[0]);
  assign raw_src[1] = source_pick(i_capture_source_select[5:3],
                                  i_channel_pin[1]);
  assign raw_src[2] = source_pick(i_capture_source_select[8:6],
                                  i_channel_pin[2]);
  assign raw_src[3] = source_pick(i_capture_source_select[11:9],
                                  i_channel_pin[3]);

  // Channels 1 and 2 pass polarity and filter, shared by capture
  // and encoder so both see the same cleaned signal.
  input_conditioner #(
    .CNT_W(FILTER_CNT_W)
  ) cond_a (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_raw(raw_src[0]),
    .i_invert(i_input_a_polarity),
    .i_filter_code(i_input_a_filter),
    .o_level(level[0])
  );

  input_conditioner #(
    .CNT_W(FILTER_CNT_W)
  ) cond_b (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_raw(raw_src[1]),
    .i_invert(i_input_b_polarity),
    .i_filter_code(i_input_b_filter),
    .o_level(level[1])
  );

  assign level[3:2] = raw_src[3:2];

  // Edges are found against the level one cycle earlier.
  wire [3:0] rise = level & ~level_q;
  wire [3:0] fall = ~level & level_q;

  // ************************************************************
  // Prescaler and encoder decode
  // ************************************************************

  // The prescaler divides by 2^prescale and makes a one-cycle tick.
  assign prescale_limit = (16'h0001 << i_prescale) - 16'h0001;
  assign tick = i_enable && (prescale_count == prescale_limit);

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prescale_count <= 16'h0000;
    end else if (!i_enable || tick) begin
      prescale_count <= 16'h0000;
    end else begin
      prescale_count <= prescale_count + 16'h0001;
    end
  end

  wire enc_on = (i_encoder_count_select != `ENC_OFF);
  wire ev_a = i_encoder_count_select[0] && (rise[0] || fall[0]);
  wire ev_b = i_encoder_count_select[1] && (rise[1] || fall[1]);
  // Channel 1 rising counts down while channel 2 is high.
  wire down_a = rise[0] ? level[1] : ~level[1];
  // Channel 2 rising counts up while channel 1 is high.
  wire down_b = rise[1] ? ~level[0] : level[0];
  // With both channels counted, simultaneous edges on them are not a legal
  // quadrature transition, so they are dropped rather than guessed at.
  wire enc_step = i_enable && enc_on && (ev_a ^ ev_b);
  wire enc_down = ev_a ? down_a : down_b;

  // Index edge detection on channel 3.
  wire idx_clear_hit =
    (i_index_clear_edge == `IDX_RISE && rise[2]) ||
    (i_index_clear_edge == `IDX_FALL && fall[2]);
  wire idx_reload_hit =
    (i_index_reload_edge == `IDX_RISE && rise[2]) ||
    (i_index_reload_edge == `IDX_FALL && fall[2]);

  // ************************************************************
  // Counter
  // ************************************************************
  reg [15:0] next_counter;
  reg next_wrap;
  reg [16:0] stepped;

  // Software write wins, then index clear, index reload, counting.
  always @* begin
    next_counter = counter_value;
    next_wrap = 1'b0;
    stepped = 17'h00000;
    if (i_counter_write) begin
      next_counter = i_counter_wdata;
    end else if (enc_on && idx_clear_hit) begin
      next_counter = `INDEX_CLEAR_VALUE;
    end else if (enc_on && idx_reload_hit) begin
      next_counter = i_reload_value;
    end else if (enc_step) begin
      if (enc_down) begin
        stepped = step_down(counter_value, i_reload_value);
      end else begin
        stepped = step_up(counter_value, i_reload_value);
      end
      next_counter = stepped[15:0];
      next_wrap = stepped[16];
    end else if (!enc_on && tick) begin
      stepped = step_up(counter_value, i_reload_value);
      next_counter = stepped[15:0];
      next_wrap = stepped[16];
    end
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      counter_value <= `COUNTER_RESET;
      o_overflow <= 1'b0;
      o_direction <= 1'b0;
      level_q <= 4'h0;
    end else begin
      counter_value <= next_counter;
      o_overflow <= next_wrap;
      level_q <= level;
      if (enc_step) begin
        o_direction <= enc_down;
      end
    end
  end

  wire dir_change = enc_step && (enc_down != o_direction);

  // ************************************************************
  // Capture and compare per channel
  // ************************************************************
  reg [3:0] cap_event;
  reg [3:0] match_now;
  reg [3:0] cmp_event;
  reg [3:0] mode;

  // Compare runs in every output mode, forced ones included, and a
  // match flags only on its first cycle so a stalled counter does not
  // keep re-raising the flag after software clears it.
  always @* begin
    cap_event = 4'h0;
    match_now = 4'h0;
    cmp_event = 4'h0;
    mode = 4'h0;
    for (ch = 0; ch < 4; ch = ch + 1) begin
      mode = i_channel_mode_control[ch*4 +: 4];
      cap_event[ch] = !mode[`MODE_OUTPUT_BIT] &&
                      edge_hit(mode, rise[ch], fall[ch]);
      match_now[ch] = mode[`MODE_OUTPUT_BIT] &&
                      (counter_value == ccr[ch]);
      cmp_event[ch] = match_now[ch] && !match_q[ch];
    end
  end

  // Capture takes the counter as it stands in the edge cycle and
  // wins over a software write landing in the same cycle.
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (ch = 0; ch < 4; ch = ch + 1) begin
        ccr[ch] <= `COMPARE_RESET;
      end
      match_q <= 4'h0;
    end else begin
      match_q <= match_now;
      for (ch = 0; ch < 4; ch = ch + 1) begin
        if (cap_event[ch]) begin
          ccr[ch] <= counter_value;
        end else if (i_compare_write[ch]) begin
          ccr[ch] <= i_compare_wdata;
        end
      end
    end
  end

  // Output drive; PWM levels follow straight from the comparisons,
  // which alone give the fixed levels at zero and above the reload.
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_channel_out <= 4'h0;
    end else begin
      for (ch = 0; ch < 4; ch = ch + 1) begin
        case (i_channel_mode_control[ch*4 +: 4])
          `MODE_FORCE_LOW: begin
            o_channel_out[ch] <= 1'b0;
          end
          `MODE_FORCE_HIGH: begin
            o_channel_out[ch] <= 1'b1;
          end
          `MODE_MATCH_LOW: begin
            if (match_now[ch]) begin
              o_channel_out[ch] <= 1'b0;
            end
          end
          `MODE_MATCH_HIGH: begin
            if (match_now[ch]) begin
              o_channel_out[ch] <= 1'b1;
            end
          end
          `MODE_PWM_POS: begin
            o_channel_out[ch] <= (counter_value >= ccr[ch]);
          end
          `MODE_PWM_REV: begin
            o_channel_out[ch] <= (counter_value < ccr[ch]);
          end
          default: begin
            o_channel_out[ch] <= 1'b0;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Status flags and interrupt request
  // ************************************************************
  wire [5:0] events = {dir_change, next_wrap, cap_event | cmp_event};
  // A zero written clears its flag; ones and idle cycles keep it.
  wire [5:0] keep_mask = i_interrupt_clear_write ?
                         i_interrupt_clear_reg : 6'h3f;
  wire [5:0] next_status = (o_interrupt_status & keep_mask) | events;

  // Events are ORed in after the clear so a same-cycle set wins.
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_interrupt_status <= `STATUS_RESET;
      o_interrupt_request <= 1'b0;
    end else begin
      o_interrupt_status <= next_status;
      o_interrupt_request <=
        |(next_status & i_interrupt_enable_reg);
    end
  end

  assign o_counter_value = counter_value;
  assign o_channel_compare_capture_1 = ccr[0];
  assign o_channel_compare_capture_2 = ccr[1];
  assign o_channel_compare_capture_3 = ccr[2];
  assign o_channel_compare_capture_4 = ccr[3];

endmodule // timer_capture_compare_encoder

`default_nettype wire

//--- quad_encoder_model.sv
// Far-side model: a quadrature encoder with phase lines and an index.
// Assumes one-cycle step pulses driven by the bench on the system clock.
`timescale 1ns/1ps
`default_nettype none

module quad_encoder_model (
  input wire logic i_clk_sys,
  input wire logic i_step,
  input wire logic i_down,
  input wire logic i_index,
  output logic o_phase_a,
  output logic o_phase_b,
  output logic o_index
);
  // ************************************************************
  // Gray-coded shaft position
  // ************************************************************
  logic [1:0] phase = 2'h0;

  // A step moves one line only, so both phases never change together.
  always @(posedge i_clk_sys) begin
    if (i_step) begin
      phase <= i_down ? phase - 2'h1 : phase + 2'h1;
    end
  end

  // Order 00, 10, 11, 01 on (a, b) is forward rotation.
  assign o_phase_a = (phase == 2'h1) || (phase == 2'h2);
  assign o_phase_b = phase[1];
  assign o_index = i_index;
endmodule // quad_encoder_model
`default_nettype wire

//--- timer_cce_chk.sv
// Port checker for the capture/compare and encoder timer.
// Assumes it is bound to the timer's top module by port name.
`timescale 1ns/1ps
`default_nettype none

module timer_cce_chk #(
  parameter FILTER_CNT_W = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic [3:0] i_prescale,
  input wire logic [15:0] i_reload_value,
  input wire logic i_counter_write,
  input wire logic [15:0] i_channel_mode_control,
  input wire logic [11:0] i_capture_source_select,
  input wire logic [3:0] i_channel_pin,
  input wire logic [1:0] i_encoder_count_select,
  input wire logic [1:0] i_index_clear_edge,
  input wire logic [5:0] i_interrupt_enable_reg,
  input wire logic i_interrupt_clear_write,
  input wire logic [5:0] i_interrupt_clear_reg,
  input wire logic [15:0] o_counter_value,
  input wire logic [15:0] o_channel_compare_capture_1,
  input wire logic [15:0] o_channel_compare_capture_2,
  input wire logic [15:0] o_channel_compare_capture_3,
  input wire logic [3:0] o_channel_out,
  input wire logic [5:0] o_interrupt_status,
  input wire logic o_overflow,
  input wire logic o_interrupt_request
);
  // ************************************************************
  // Outputs are registered, so most checks look one edge back.
  // ************************************************************
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  // A plain timer tick taken while the counter sits at its top.
  sequence tick_at_top;
    $past(i_rst_n) && $past(i_enable) && !$past(i_counter_write) &&
    $past(i_encoder_count_select) == 2'h0 && $past(i_prescale) == 4'h0 &&
    $past(o_counter_value) >= $past(i_reload_value);
  endsequence

  // A rising pin edge on channel 3 armed for rising capture.
  sequence ch3_rise;
    i_channel_mode_control[11:8] == 4'h1 &&
    i_capture_source_select[8:6] == 3'h0 && $rose(i_channel_pin[2]);
  endsequence

  wrap_at_top_a: assert property (
    tick_at_top |-> o_overflow && o_counter_value == 16'h0000)
    else $error("Counter did not wrap to zero at the top value.");
  capture_flag_a: assert property (
    ch3_rise |-> ##[1:2] o_interrupt_status[2])
    else $error("Channel 3 edge did not raise its event flag.");
  force_low_a: assert property (
    $past(i_rst_n) && $past(i_channel_mode_control[3:0]) == 4'h8
    |-> !o_channel_out[0]) else $error("Forced low output is high.");
  force_high_a: assert property (
    $past(i_rst_n) && $past(i_channel_mode_control[3:0]) == 4'h9
    |-> o_channel_out[0]) else $error("Forced high output is low.");
  match_high_a: assert property (
    $past(i_rst_n) && $past(i_channel_mode_control[3:0]) == 4'hb &&
    $past(o_counter_value) == $past(o_channel_compare_capture_1)
    |-> o_channel_out[0]) else $error("Match did not set output high.");
  pwm_pos_a: assert property (
    $past(i_rst_n) && $past(i_channel_mode_control[7:4]) == 4'he
    |-> o_channel_out[1] == ($past(o_counter_value) >=
    $past(o_channel_compare_capture_2))) else $error("Bad positive PWM.");
  pwm_rev_a: assert property (
    $past(i_rst_n) && $past(i_channel_mode_control[11:8]) == 4'hf
    |-> o_channel_out[2] == ($past(o_counter_value) <
    $past(o_channel_compare_capture_3))) else $error("Bad reverse PWM.");
  irq_level_a: assert property ($past(i_rst_n) |->
    o_interrupt_request == |(o_interrupt_status &
    $past(i_interrupt_enable_reg))) else $error("Bad request level.");
  clear_keep_a: assert property (
    i_interrupt_clear_write && i_interrupt_clear_reg[4] &&
    o_interrupt_status[4] |=> o_interrupt_status[4])
    else $error("Clear bit at one dropped the flag.");
  clear_zero_a: assert property (
    i_interrupt_clear_write && !i_interrupt_clear_reg[4]
    |=> !o_interrupt_status[4] || o_overflow)
    else $error("Clear bit at zero kept the flag.");
  index_clear_a: assert property (
    i_index_clear_edge == 2'h1 && i_encoder_count_select != 2'h0 &&
    i_capture_source_select[8:6] == 3'h0 && !i_counter_write &&
    $rose(i_channel_pin[2]) |-> ##[1:3] o_counter_value == 16'h0000)
    else $error("Index edge did not clear the counter.");
endmodule // timer_cce_chk

bind timer_capture_compare_encoder timer_cce_chk #(
  .FILTER_CNT_W(FILTER_CNT_W)) timer_cce_chk_inst (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_enable(i_enable),
  .i_prescale(i_prescale), .i_reload_value(i_reload_value),
  .i_counter_write(i_counter_write),
  .i_channel_mode_control(i_channel_mode_control),
  .i_capture_source_select(i_capture_source_select),
  .i_channel_pin(i_channel_pin),
  .i_encoder_count_select(i_encoder_count_select),
  .i_index_clear_edge(i_index_clear_edge),
  .i_interrupt_enable_reg(i_interrupt_enable_reg),
  .i_interrupt_clear_write(i_interrupt_clear_write),
  .i_interrupt_clear_reg(i_interrupt_clear_reg),
  .o_counter_value(o_counter_value),
  .o_channel_compare_capture_1(o_channel_compare_capture_1),
  .o_channel_compare_capture_2(o_channel_compare_capture_2),
  .o_channel_compare_capture_3(o_channel_compare_capture_3),
  .o_channel_out(o_channel_out), .o_interrupt_status(o_interrupt_status),
  .o_overflow(o_overflow), .o_interrupt_request(o_interrupt_request));
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the capture/compare and encoder timer.
// Assumes the encoder model drives channels 1 to 3 and the bench the rest.
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top;
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0, en = 1'b0, cw = 1'b0, pola = 1'b0;
  logic icw = 1'b0, qs = 1'b0, qd = 1'b0, zi = 1'b0, p4 = 1'b0;
  logic [3:0] presc = 4'h0, cmw = 4'h0;
  logic [15:0] top = 16'hffff, cwd = 16'h0000, mode = 16'h0000;
  logic [15:0] ccd = 16'h0000, exp = 16'h0000, exp4 = 16'h0000;
  logic [11:0] srcsel = 12'h000;
  logic [4:0] alt = 5'h00;
  logic [1:0] esel = 2'h0, iclr = 2'h0, irel = 2'h0;
  logic [2:0] fa = 3'h0;
  logic [5:0] ien = 6'h00, icr = 6'h3f;
  logic [7:0] hi2, hi3, ehi;
  logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  logic [15:0] vals [4] = '{16'h0000, 16'h0003, 16'h0009, 16'h000c};
  wire a, b, z, down, ovf, irq;
  wire [15:0] count, c1, c2, c3, c4;
  wire [3:0] out;
  wire [5:0] st;
  int error_cnt = 0, compares = 0;

  quad_encoder_model quad_encoder_model_inst (.i_clk_sys(i_clk_sys),
    .i_step(qs), .i_down(qd), .i_index(zi), .o_phase_a(a), .o_phase_b(b),
    .o_index(z));

  timer_capture_compare_encoder #(.FILTER_CNT_W(8))
    timer_capture_compare_encoder_inst (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_enable(en),
    .i_prescale(presc), .i_reload_value(top), .i_counter_write(cw),
    .i_counter_wdata(cwd), .i_channel_mode_control(mode),
    .i_capture_source_select(srcsel), .i_compare_write(cmw),
    .i_compare_wdata(ccd), .i_channel_pin({p4, z, b, a}),
    .i_uart_rx_one(alt[0]), .i_uart_rx_two(alt[1]),
    .i_voltage_comparator_one(alt[2]), .i_voltage_comparator_two(alt[3]),
    .i_low_voltage_detector_out(alt[4]), .i_encoder_count_select(esel),
    .i_input_a_polarity(pola), .i_input_b_polarity(1'b0),
    .i_input_a_filter(fa), .i_input_b_filter(3'h0),
    .i_index_reload_edge(irel), .i_index_clear_edge(iclr),
    .i_interrupt_enable_reg(ien), .i_interrupt_clear_write(icw),
    .i_interrupt_clear_reg(icr), .o_counter_value(count),
    .o_channel_compare_capture_1(c1), .o_channel_compare_capture_2(c2),
    .o_channel_compare_capture_3(c3), .o_channel_compare_capture_4(c4),
    .o_channel_out(out), .o_interrupt_status(st), .o_direction(down),
    .o_overflow(ovf), .o_interrupt_request(irq));

  // ************************************************************
  // Clock, access tasks and verdict
  // ************************************************************
  // Half period of 50 ns gives the 10 MHz system clock.
  always #50 i_clk_sys = ~i_clk_sys;

  // Every drive happens on the falling edge, away from sampling.
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task automatic load_count(input logic [15:0] v);
    cwd = v;
    cw = 1'b1;
    tick(1);
    cw = 1'b0;
  endtask
  task automatic load_cmp(input logic [3:0] m, input logic [15:0] v);
    ccd = v;
    cmw = m;
    tick(1);
    cmw = 4'h0;
  endtask
  task automatic clr(input logic [5:0] m);
    icr = m;
    icw = 1'b1;
    tick(1);
    icw = 1'b0;
    icr = 6'h3f;
  endtask
  // A step is held long enough to pass the widest filter in use.
  task automatic qstep(input logic d);
    qd = d;
    qs = 1'b1;
    tick(1);
    qs = 1'b0;
    tick(6);
  endtask
  task automatic zset(input logic l);
    zi = l;
    tick(4);
  endtask
  task automatic done(input string name);
    $display("test %0s done", name);
  endtask
  task automatic complete_run;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A hung run is cut short and counted as a failure.
  initial begin
    #6ms;
    error_cnt++;
    complete_run();
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    tick(6);
    i_rst_n = 1'b1;
    tick(1);
    `CHK(st, 6'h00)
    top = 16'h0002;
    en = 1'b1;
    for (int k = 1; k < 4; k++) begin
      tick(1);
      `CHK(count, 16'(k % 3))
    end
    `CHK({ovf, st[4]}, 2'h3)
    en = 1'b0;
    ien = 6'h10;
    tick(1);
    `CHK(irq, 1'b1)
    clr(6'h3f);
    `CHK(st[4], 1'b1)
    clr(6'h2f);
    `CHK({irq, st}, 7'h00)
    ien = 6'h00;
    load_count(16'h0000);
    top = 16'hffff;
    presc = 4'h2;
    en = 1'b1;
    tick(12);
    `CHK(count, 16'h0003)
    en = 1'b0;
    presc = 4'h0;
    done("timer");
    // Channel 3 edge modes, then each alternate source on channel 4.
    for (int m = 1; m < 4; m++) begin
      mode[11:8] = 4'(m);
      load_count(16'(m * 16));
      zset(1'b1);
      if (m != 2) exp = 16'(m * 16);
      `CHK(c3, exp)
      load_count(16'(m * 16 + 1));
      zset(1'b0);
      if (m != 1) exp = 16'(m * 16 + 1);
      `CHK({st[2], c3}, {1'b1, exp})
      clr(6'h3b);
    end
    mode = 16'h1000;
    for (int s = 0; s < 5; s++) begin
      srcsel[11:9] = codes[s];
      load_count(16'(s + 256));
      alt = ~(5'h01 << s);
      p4 = 1'b1;
      tick(3);
      `CHK(c4, exp4)
      alt[s] = 1'b1;
      exp4 = 16'(s + 256);
      tick(3);
      `CHK(c4, exp4)
      alt = 5'h00;
      p4 = 1'b0;
      tick(3);
    end
    done("capture");
    top = 16'h0009;
    load_cmp(4'h1, 16'h0005);
    mode = 16'h000b;
    en = 1'b1;
    tick(12);
    `CHK({out[0], st[0]}, 2'h3)
    mode[3:0] = 4'ha;
    tick(12);
    `CHK(out[0], 1'b0)
    clr(6'h3e);
    mode[3:0] = 4'h9;
    tick(12);
    `CHK({out[0], st[0]}, 2'h3)
    mode[3:0] = 4'h8;
    tick(2);
    `CHK(out[0], 1'b0)
    mode = 16'h0fe0;
    for (int v = 0; v < 4; v++) begin
      load_cmp(4'h6, vals[v]);
      tick(12);
      hi2 = 8'h00;
      hi3 = 8'h00;
      repeat (10) begin
        tick(1);
        hi2 = hi2 + out[1];
        hi3 = hi3 + out[2];
      end
      ehi = (vals[v] > 16'h0009) ? 8'h00 : 8'(10 - vals[v]);
      `CHK(hi2, ehi)
      `CHK(hi3, 8'h0a - ehi)
    end
    en = 1'b0;
    mode = 16'h0000;
    done("compare");
    top = 16'hffff;
    fa = 3'h1;
    en = 1'b1;
    for (int m = 1; m < 4; m++) begin
      esel = 2'(m);
      load_count(16'h0100);
      clr(6'h1f);
      repeat (4) qstep(1'b0);
      `CHK(count, (m == 3) ? 16'h0104 : 16'h0102)
      `CHK(down, 1'b0)
      repeat (4) qstep(1'b1);
      `CHK({down, st[5], count}, {2'h3, 16'h0100})
    end
    esel = 2'h0;
    pola = 1'b1;
    tick(8);
    esel = 2'h1;
    load_count(16'h0100);
    repeat (4) qstep(1'b0);
    `CHK(count, 16'h00fe)
    esel = 2'h0;
    pola = 1'b0;
    tick(8);
    esel = 2'h1;
    iclr = 2'h1;
    load_count(16'h0050);
    zset(1'b1);
    `CHK(count, 16'h0000)
    iclr = 2'h0;
    irel = 2'h2;
    top = 16'h0777;
    zset(1'b0);
    `CHK(count, 16'h0777)
    done("encoder");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
